// File: bench/sac_link_checker.sv
/*
  Checker for the link between host end and converter end.
  Assumes the interface's lines as plain inputs and one 20 MHz clock.
*/
module sac_link_checker (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // link lines
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_di,
  input wire logic host_oe_n,
  input wire logic dev_do,
  input wire logic dev_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  int   hi_cnt;
  int   rise_cnt;
  int   high_len;
  logic sclk_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // select-high run; starts saturated so the first frame is legal
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) hi_cnt <= 100;
    else hi_cnt <= cs_n ? ((hi_cnt < 100) ? hi_cnt + 1 : 100) : 0;
  end

  // link clock rises inside the current frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q   <= 1'b0;
      rise_cnt <= 0;
    end else begin
      sclk_q   <= sclk;
      rise_cnt <= cs_n ? 0 : rise_cnt + int'(sclk && !sclk_q);
    end
  end

  // length of the current high phase of the link clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) high_len <= 0;
    else high_len <= sclk ? high_len + 1 : 0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cs_gap;
    $fell(cs_n) |-> hi_cnt >= 10;
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select high gap too short");
  property p_frame_len;
    $rose(cs_n) |-> rise_cnt >= 18;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame has too few link clocks");
  property p_sclk_rate;
    $fell(sclk) |-> high_len >= 10;
  endproperty
  a_sclk_rate: assert property (p_sclk_rate)
    else $error("link clock high phase too short");
  property p_di_hold;
    sclk |-> $stable(host_di);
  endproperty
  a_di_hold: assert property (p_di_hold)
    else $error("host data moved while link clock high");
  property p_do_fall;
    !dev_oe_n && $changed(dev_do) |-> !sclk;
  endproperty
  a_do_fall: assert property (p_do_fall)
    else $error("device data moved while link clock high");
  property p_one_driver;
    !dev_oe_n |-> host_oe_n && !cs_n || !$past(cs_n, 4);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("device drives outside its read window");
  property p_release;
    $rose(cs_n) |-> ##[1:5] dev_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released after deselect");
  property p_idle_quiet;
    cs_n [*5] |-> dev_oe_n && !sclk;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("link active while deselected");
  property p_setting_first;
    $fell(dev_oe_n) |-> rise_cnt == 5;
  endproperty
  a_setting_first: assert property (p_setting_first)
    else $error("device output enabled at wrong clock");
  property p_host_first;
    $fell(host_oe_n) |-> rise_cnt == 0 && !cs_n;
  endproperty
  a_host_first: assert property (p_host_first)
    else $error("host setting not at frame start");
endmodule

// File: bench/serial_adc_conversion_frame_tb.sv
/*
  Testbench: host end and converter end joined by one link, a spare
  converter end driven by hand to abandon a frame. Assumes 20 MHz clk.
*/
module serial_adc_conversion_frame_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        clk, sys_rst, req_valid, req_ready, req_single, req_odd;
  logic        res_valid, res_ready, strobe, shut, abort, shut_b, abort_b;
  logic [11:0] res_data, last_result, zero_in, one_in, d;
  int          err_total, comparisons, cycles, strobes, aborts;
  // expected codes per mode: single zero, single one, zero-one, one-zero
  logic [11:0] exp_tab [4] = '{12'hA5C, 12'h3F1, 12'h66B, 12'h000};

  // main link joins both data lines; the spare one keeps four wires
  sac_link_if #(.THREE_WIRE(1'b1)) link ();
  sac_link_if link_b ();
  sac_host_end u_sac_host_end (.clk, .sys_rst, .link(link), .req_valid,
    .req_ready, .req_single, .req_odd, .res_valid, .res_ready, .res_data);
  sac_device_end u_sac_device_end (.clk, .sys_rst, .link(link),
    .analog_input_zero(zero_in), .analog_input_one(one_in), .last_result,
    .result_strobe(strobe), .in_shutdown(shut), .frame_abort(abort));
  sac_device_end u_sac_device_end_b (.clk, .sys_rst, .link(link_b),
    .analog_input_zero(zero_in), .analog_input_one(one_in),
    .last_result(), .result_strobe(), .in_shutdown(shut_b),
    .frame_abort(abort_b));
  sac_link_checker u_sac_link_checker (.clk, .sys_rst, .cs_n(link.cs_n),
    .sclk(link.sclk), .host_di(link.host_di), .host_oe_n(link.host_oe_n),
    .dev_do(link.dev_do), .dev_oe_n(link.dev_oe_n));

  // clock and hang guard; guard covers about 66 frames, over three times the 20 run
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (strobe === 1'b1) strobes++;
    if (abort === 1'b1) aborts++;
    if (cycles == 25000) begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one request; waits for ready, then holds valid for one edge only
  task automatic convert(input int i);
    #1;
    for (int n = 0; n < 2000 && req_ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    req_valid  <= 1'b1;
    req_single <= !i[1];
    req_odd    <= i[0];
    @(posedge clk);
    req_valid  <= 1'b0;
  endtask

  // take one result word from the buffer
  task automatic pop(output logic [11:0] w);
    #1;
    for (int n = 0; n < 1000 && res_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    w = res_data;
    @(posedge clk);
    res_ready <= 1'b1;
    @(posedge clk);
    res_ready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {req_valid, req_single, req_odd, res_ready} = 4'h0;
    zero_in = 12'hA5C;
    one_in  = 12'h3F1;
    {link_b.cs_n, link_b.sclk, link_b.host_di, link_b.host_oe_n} = 4'h8;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // every input mode once, shutdown seen in and out of a frame
    for (int i = 0; i < 4; i++) begin
      convert(i);
      repeat (50) @(posedge clk);
      #1 check({11'h0, shut}, 12'h000);
      pop(d);
      // select release needs a few clocks through the device syncs
      repeat (4) @(posedge clk);
      #1 check(d, exp_tab[i]);
      check(last_result, exp_tab[i]);
      check({11'h0, shut}, 12'h001);
    end
    // fill the buffer with nobody draining, then empty it in order
    for (int i = 0; i < 16; i++) convert(i % 4);
    repeat (600) @(posedge clk);
    #1 check({11'h0, req_ready}, 12'h000);
    for (int i = 0; i < 16; i++) begin
      pop(d);
      check(d, exp_tab[i % 4]);
    end
    // spare link: deselect in the middle of conversion
    @(posedge clk);
    link_b.cs_n    <= 1'b0;
    link_b.host_di <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      repeat (10) @(posedge clk);
      link_b.sclk    <= 1'b1;
      repeat (10) @(posedge clk);
      link_b.sclk    <= 1'b0;
      link_b.host_di <= k[0];
    end
    // device is mid-conversion and driving its output here
    #1 check({11'h0, link_b.dev_oe_n}, 12'h000);
    @(posedge clk);
    link_b.cs_n <= 1'b1;
    d = 12'h000;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1 if (abort_b === 1'b1) d = 12'h001;
    end
    check(d, 12'h001);
    check({11'h0, link_b.dev_oe_n}, 12'h001);
    check({11'h0, shut_b}, 12'h001);
    // twenty whole frames on the main link, none of them cut short
    check(12'(strobes), 12'h014);
    check(12'(aborts), 12'h000);
    test_done();
  end
endmodule

// File: rtl/sac_device_end.sv
/*
  Converter end: setting shift-in, sample-and-hold, successive
  approximation and serial result shift-out. Analog inputs arrive as
  12-bit codes. All link pins are synchronised to clk; the link clock
  must stay well below clk/8 for edge detection to hold.
*/
module sac_device_end #(
  parameter int RES = sac_pkg::RES_BITS
) (
  // system
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // link
  sac_link_if.dev             link,
  // analog inputs as codes
  input  wire logic [RES-1:0] analog_input_zero,
  input  wire logic [RES-1:0] analog_input_one,
  // status
  output logic     [RES-1:0]  last_result,
  output logic                result_strobe,
  output logic                in_shutdown,
  output logic                frame_abort
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_SETUP   = 5'h02,
    ST_SAMPLE  = 5'h04,
    ST_CONVERT = 5'h08,
    ST_DONE    = 5'h10
  } sac_dev_state_t;

  sac_dev_state_t state;
  logic [1:0]     cs_sync;
  logic [1:0]     ck_sync;
  logic [1:0]     di_sync;
  logic           ck_prev;
  logic [1:0]     set_cnt;
  logic [2:0]     fall_cnt;
  logic           single;
  logic           odd;
  logic [RES-1:0] held;
  logic [RES-1:0] sar;
  logic [3:0]     bit_idx;

  // pins pass two flops before any logic reads them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_sync <= 2'h3;
      ck_sync <= 2'h0;
      di_sync <= 2'h0;
      ck_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], link.cs_n};
      ck_sync <= {ck_sync[0], link.sclk};
      di_sync <= {di_sync[0], link.din_line};
      ck_prev <= ck_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire            deselect = cs_sync[1];
  wire            rise     = !deselect && ck_sync[1] && !ck_prev;
  wire            fall     = !deselect && !ck_sync[1] && ck_prev;
  wire            din      = di_sync[1];
  wire [RES-1:0]  diff_zo  = (analog_input_zero > analog_input_one) ?
                             analog_input_zero - analog_input_one :
                             {RES{1'b0}};
  wire [RES-1:0]  diff_oz  = (analog_input_one > analog_input_zero) ?
                             analog_input_one - analog_input_zero :
                             {RES{1'b0}};
  // single-ended picks one input, differential clamps at zero
  wire [RES-1:0]  sel_value = single ?
                              (odd ? analog_input_one : analog_input_zero) :
                              (odd ? diff_oz : diff_zo);
  wire [RES-1:0]  trial_bit = {{(RES-1){1'b0}}, 1'b1} << bit_idx;
  wire [RES-1:0]  trial     = sar | trial_bit;
  wire            keep      = trial <= held;
  wire            abandon   = deselect &&
                              (state != ST_IDLE) && (state != ST_DONE);

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= ST_IDLE;
      set_cnt       <= 2'h0;
      fall_cnt      <= 3'h0;
      single        <= 1'b0;
      odd           <= 1'b0;
      held          <= {RES{1'b0}};
      sar           <= {RES{1'b0}};
      bit_idx       <= 4'h0;
      link.dev_do   <= 1'b0;
      link.dev_oe_n <= 1'b1;
      last_result   <= {RES{1'b0}};
      result_strobe <= 1'b0;
      in_shutdown   <= 1'b1;
      frame_abort   <= 1'b0;
    end else begin
      result_strobe <= 1'b0;
      frame_abort   <= abandon;
      in_shutdown   <= deselect && (state == ST_IDLE);
      if (deselect) begin
        // any deselect drops the frame and floats the output
        state         <= ST_IDLE;
        link.dev_oe_n <= 1'b1;
        set_cnt       <= 2'h0;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_SETUP;
          end
          ST_SETUP: begin
            // leading zeros before the start bit are ignored
            if (rise && (set_cnt != 2'h0 || din)) begin
              set_cnt <= set_cnt + 2'h1;
              if (set_cnt == 2'h1) single <= din;
              if (set_cnt == 2'h2) begin
                odd      <= din;
                fall_cnt <= 3'h0;
                state    <= ST_SAMPLE;
              end
            end
          end
          ST_SAMPLE: begin
            held <= sel_value;
            if (fall) begin
              fall_cnt <= fall_cnt + 3'h1;
              if (fall_cnt == 3'(sac_pkg::SAMPLE_FALLS - 1)) begin
                // freeze here; null bit goes out first
                held          <= held;
                sar           <= {RES{1'b0}};
                bit_idx       <= 4'(RES - 1);
                link.dev_do   <= 1'b0;
                link.dev_oe_n <= 1'b0;
                state         <= ST_CONVERT;
              end
            end
          end
          ST_CONVERT: begin
            if (fall) begin
              // one bit per falling edge, msb first
              sar         <= keep ? trial : sar;
              link.dev_do <= keep;
              bit_idx     <= bit_idx - 4'h1;
              if (bit_idx == 4'h0) begin
                last_result   <= keep ? trial : sar;
                result_strobe <= 1'b1;
                state         <= ST_DONE;
              end
            end
          end
          ST_DONE: begin
            // output stays on the lsb until select rises
            state <= ST_DONE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// File: rtl/sac_host_end.sv
/*
  Host end: generates the link clock by dividing clk, runs one frame per
  request and buffers the results in a FIFO. Assumes a converter end that
  follows the frame layout in sac_pkg.
*/
module sac_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // system
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  // extra pointer bit tells full from empty
  wire full  = (wr_ptr[AW] != rd_ptr[AW]) &&
               (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = wr_ptr == rd_ptr;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // pointers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) wr_ptr <= wr_ptr + 1'b1;
      if (out_ready && !empty) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage has no reset, only written words are ever read
  always_ff @(posedge clk) begin
    if (in_valid && !full) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

module sac_host_end #(
  parameter int RES   = sac_pkg::RES_BITS,
  parameter int DEPTH = sac_pkg::FIFO_DEPTH
) (
  // system
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // link
  sac_link_if.host            link,
  // conversion request
  input  wire logic           req_valid,
  output logic                req_ready,
  input  wire logic           req_single,
  input  wire logic           req_odd,
  // results
  output logic                res_valid,
  input  wire logic           res_ready,
  output logic     [RES-1:0]  res_data
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HS_IDLE  = 3'h1,
    HS_FRAME = 3'h2,
    HS_GAP   = 3'h4
  } sac_host_state_t;

  sac_host_state_t state;
  logic [1:0]     do_sync;
  logic [4:0]     div;
  logic [4:0]     rise_cnt;
  logic [3:0]     gap;
  logic [2:0]     set_bits;
  logic [RES-1:0] shift;
  logic           push;
  logic           fifo_ready;

  localparam logic [4:0] HALF  = 5'(sac_pkg::SCLK_HALF_CYC - 1);
  localparam logic [3:0] GAPC  = 4'(sac_pkg::CS_HIGH_CYC - 1);
  localparam logic [4:0] LAST  = 5'(sac_pkg::FRAME_SCLKS);
  localparam logic [4:0] FIRST = 5'(sac_pkg::FIRST_DATA_RISE);
  localparam logic [4:0] FINAL = 5'(sac_pkg::FIRST_DATA_RISE + RES - 1);

  wire half_end = div == HALF;
  wire do_rise  = (state == HS_FRAME) && half_end && !link.sclk;
  wire do_fall  = (state == HS_FRAME) && half_end && link.sclk;
  wire take     = req_valid && req_ready;
  assign req_ready = (state == HS_IDLE) && fifo_ready;

  // dout comes from the far end and is synchronised first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) do_sync <= 2'h3;
    else do_sync <= {do_sync[0], link.dout_line};
  end

  // ----------------------------------------------------------------
  // frame generator
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state          <= HS_IDLE;
      div            <= 5'h0;
      rise_cnt       <= 5'h0;
      gap            <= 4'h0;
      set_bits       <= 3'h0;
      shift          <= {RES{1'b0}};
      push           <= 1'b0;
      link.cs_n      <= 1'b1;
      link.sclk      <= 1'b0;
      link.host_di   <= 1'b0;
      link.host_oe_n <= 1'b1;
    end else begin
      push <= 1'b0;
      div  <= (state != HS_FRAME || half_end) ? 5'h0 : div + 5'h1;
      case (state)
        HS_IDLE: begin
          if (take) begin
            // start bit leads; setting bits follow
            set_bits       <= {1'b1, req_single, req_odd};
            link.cs_n      <= 1'b0;
            link.host_di   <= 1'b1;
            link.host_oe_n <= 1'b0;
            rise_cnt       <= 5'h0;
            state          <= HS_FRAME;
          end
        end
        HS_FRAME: begin
          if (do_rise) begin
            link.sclk <= 1'b1;
            rise_cnt  <= rise_cnt + 5'h1;
            if (rise_cnt + 5'h1 >= FIRST && rise_cnt + 5'h1 <= FINAL)
              shift <= {shift[RES-2:0], do_sync[1]};
          end
          if (do_fall) begin
            // data changes on the falling edge, stable for the rise
            link.sclk <= 1'b0;
            if (rise_cnt < 5'(sac_pkg::SET_BITS)) begin
              link.host_di <= set_bits[2 - rise_cnt[1:0]];
            end else begin
              link.host_oe_n <= 1'b1;
            end
            if (rise_cnt == LAST) begin
              link.cs_n <= 1'b1;
              push      <= 1'b1;
              gap       <= 4'h0;
              state     <= HS_GAP;
            end
          end
        end
        HS_GAP: begin
          gap <= gap + 4'h1;
          if (gap == GAPC) state <= HS_IDLE;
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result buffer; a full buffer holds off new requests
  // ----------------------------------------------------------------
  sac_fifo #(
    .WIDTH (RES),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (shift),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );
endmodule

// File: rtl/sac_link_if.sv
/*
  Link between host end and converter end: select, clock and data lines.
  Resolves the shared wires from the output enables; an undriven line
  reads high as if pulled up.
*/
interface sac_link_if #(
  parameter bit THREE_WIRE = 1'b0
);
  // ----------------------------------------------------------------
  // driven lines and resolved wires
  // ----------------------------------------------------------------
  logic cs_n;
  logic sclk;
  logic host_di;
  logic host_oe_n;
  logic dev_do;
  logic dev_oe_n;
  logic din_line;
  logic dout_line;

  // joined data wire when three wires are used
  assign din_line  = THREE_WIRE ?
                     (!dev_oe_n ? dev_do : (!host_oe_n ? host_di : 1'b1)) :
                     (!host_oe_n ? host_di : 1'b1);
  assign dout_line = THREE_WIRE ? din_line :
                     (!dev_oe_n ? dev_do : 1'b1);

  modport host (
    output cs_n, sclk, host_di, host_oe_n,
    input  dout_line
  );
  modport dev (
    input  cs_n, sclk, din_line,
    output dev_do, dev_oe_n
  );
endinterface

// File: rtl/sac_pkg.sv
/*
  Shared constants for the serial converter link: frame layout, link timing
  and result width. Assumes both ends run on one 20 MHz system clock.
*/
package sac_pkg;
  // ----------------------------------------------------------------
  // clock and link timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ   = 20;
  localparam int SCLK_PERIOD_NS = 1000;   // 1.0 MHz ceiling
  localparam int SCLK_HALF_CYC  =
    ((SCLK_PERIOD_NS * CLK_FREQ_MHZ + 999) / 1000 + 1) / 2;
  localparam int CS_HIGH_NS     = 500;
  localparam int CS_HIGH_CYC    = (CS_HIGH_NS * CLK_FREQ_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // frame layout, counted in link clock edges
  // ----------------------------------------------------------------
  localparam int RES_BITS       = 12;
  localparam int SET_BITS       = 3;      // start, single/diff, odd/sign
  localparam int SAMPLE_FALLS   = 3;      // 2.5 clocks after last setting
  localparam int FIRST_DATA_RISE = 7;     // null bit at rise 6
  localparam int FRAME_SCLKS    = 18;
  localparam int FIFO_DEPTH     = 16;
endpackage
